//--- hdl/quad_dac_serial_load.sv
/*
  Serial load front end of a quad 12-bit converter with an AHB-Lite register slave.
  Assumes the strobe, serial clock and data pins are asynchronous to clk and that the
  serial clock is much slower than clk, so each of its edges is seen by sampling.
*/
`timescale 1ns/1ps
module quad_dac_serial_load #(
  parameter logic [7:0] LOAD_DECODE = qdac_pkg::LOAD_DECODE_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire qdac_pkg::serial_pins_s link_pins,
  output qdac_pkg::conv_out_s conv_out
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    qdac_pkg::link_state_e st;
    logic [qdac_pkg::CNT_W-1:0] bit_cnt;
    logic [qdac_pkg::FRAME_W-1:0] shreg;
    logic sclk_prev;
    logic commit;
    logic [qdac_pkg::FRAME_W-1:0] frame;
    logic [qdac_pkg::EVT_W-1:0] frames;
    logic [qdac_pkg::EVT_W-1:0] aborts;
    logic en;
    logic [qdac_pkg::CH_N-1:0] shutdown;
    logic [qdac_pkg::CH_N-1:0][1:0] term;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic ready;
    logic [31:0] rdata;
  } top_state_s;

  top_state_s state_reg;
  top_state_s state_next;
  qdac_pkg::serial_pins_s pins_s;
  qdac_pkg::bank_wr_s bank_wr;
  logic [qdac_pkg::DATA_W-1:0] bank_rdata;
  logic [qdac_pkg::CH_N-1:0][qdac_pkg::DATA_W-1:0] conv_code;
  logic strobe_low;
  logic sclk_fall;
  logic addr_take;
  logic [2:0] bank_raddr;
  logic [1:0] load_code;
  logic [1:0] load_act;
  logic pd_cmd;
  logic [qdac_pkg::CH_N-1:0] pd_mask;
  logic [qdac_pkg::CH_N-1:0] pick_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bank

  pin_sync #(
    .W(3),
    .RST_VAL(qdac_pkg::PINS_IDLE)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .d(link_pins),
    .q(pins_s)
  );

  assign bank_raddr = {haddr[5], haddr[3:2]};

  chan_reg_bank u_bank (
    .clk(clk),
    .srst(srst),
    .wr(bank_wr),
    .raddr(bank_raddr),
    .rdata(bank_rdata),
    .conv_code(conv_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame decode of a committed word

  assign strobe_low = ~pins_s.sync_n & state_reg.en;
  assign sclk_fall = state_reg.sclk_prev & ~pins_s.sclk;
  assign load_code = {state_reg.frame[qdac_pkg::LOAD_CTL_HI_POS],
                      state_reg.frame[qdac_pkg::LOAD_CTL_LO_POS]};
  assign load_act = LOAD_DECODE[{load_code, 1'b0} +: 2];
  assign pd_cmd = state_reg.frame[qdac_pkg::LOAD_CTL_HI_POS:qdac_pkg::CHAN_PICK_LO_POS]
                  == qdac_pkg::PD_PREFIX;
  assign pick_mask = qdac_pkg::chan_onehot({state_reg.frame[qdac_pkg::CHAN_PICK_HI_POS],
                                            state_reg.frame[qdac_pkg::CHAN_PICK_LO_POS]});
  assign pd_mask = state_reg.frame[qdac_pkg::ALL_CHANNEL_FLAG_POS] ? '1 :
                   qdac_pkg::chan_onehot(state_reg.frame[qdac_pkg::PD_CHAN_HI_POS:
                                                          qdac_pkg::PD_CHAN_LO_POS]);

  always_comb
  begin
    bank_wr = '0;
    bank_wr.wdata = state_reg.frame[qdac_pkg::DATA_W-1:0];
    if (state_reg.commit && !pd_cmd)
    begin
      bank_wr.in_we = load_act[0] ? pick_mask : '0;
      // The selected converter takes the frame data whenever load_act[1] updates it
      bank_wr.cv_from_shift = pick_mask;
      if (load_act[1])
      begin
        bank_wr.cv_we = (load_code == qdac_pkg::LOAD_ALL_UPDATE) ? '1 : pick_mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link state machine and register slave

  assign addr_take = hsel && hready && htrans[1];

  always_comb
  begin
    state_next = state_reg;
    state_next.sclk_prev = pins_s.sclk;
    state_next.commit = 1'b0;
    if (!strobe_low)
    begin
      state_next.bit_cnt = '0;
    end
    unique case (state_reg.st)
      qdac_pkg::st_idle:
      begin
        if (strobe_low)
        begin
          state_next.st = qdac_pkg::st_shift;
        end
      end
      qdac_pkg::st_shift:
      begin
        if (!strobe_low)
        begin
          state_next.st = qdac_pkg::st_idle;
          state_next.aborts = state_reg.aborts + 16'h0001;
        end
        else if (sclk_fall)
        begin
          state_next.shreg = {state_reg.shreg[qdac_pkg::FRAME_W-2:0], pins_s.sdin};
          state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
          if (state_reg.bit_cnt == qdac_pkg::LAST_BIT_IDX)
          begin
            state_next.st = qdac_pkg::st_hold;
            state_next.commit = 1'b1;
            state_next.frame = {state_reg.shreg[qdac_pkg::FRAME_W-2:0], pins_s.sdin};
            state_next.frames = state_reg.frames + 16'h0001;
          end
        end
      end
      qdac_pkg::st_hold:
      begin
        // Host may only release after the sixteenth edge; wait for that release
        if (!strobe_low)
        begin
          state_next.st = qdac_pkg::st_idle;
        end
      end
      default:
      begin
        state_next.st = qdac_pkg::st_idle;
      end
    endcase
    // Power-down frames and converter updates of a committed word
    if (state_reg.commit && pd_cmd)
    begin
      for (int i = 0; i < qdac_pkg::CH_N; i++)
      begin
        if (pd_mask[i])
        begin
          state_next.shutdown[i] = 1'b1;
          state_next.term[i] = state_reg.frame[qdac_pkg::PD_TERM_HI_POS:
                                               qdac_pkg::PD_TERM_LO_POS];
        end
      end
    end
    else
    begin
      state_next.shutdown = state_reg.shutdown & ~bank_wr.cv_we;
    end
    // Bus: one wait state for every transfer
    if (addr_take)
    begin
      state_next.dphase = 1'b1;
      state_next.dwrite = hwrite;
      state_next.daddr = haddr[7:0];
      state_next.ready = 1'b0;
    end
    else if (state_reg.dphase)
    begin
      state_next.dphase = 1'b0;
      state_next.ready = 1'b1;
      state_next.rdata = '0;
      if (state_reg.dwrite)
      begin
        if (state_reg.daddr == qdac_pkg::OFS_CTRL)
        begin
          state_next.en = hwdata[qdac_pkg::CTRL_EN_POS];
        end
      end
      else if (state_reg.daddr[1:0] == 2'h0)
      begin
        if (state_reg.daddr == qdac_pkg::OFS_CTRL)
        begin
          state_next.rdata[qdac_pkg::CTRL_EN_POS] = state_reg.en;
        end
        else if (state_reg.daddr == qdac_pkg::OFS_FRAMES)
        begin
          state_next.rdata[qdac_pkg::EVT_W-1:0] = state_reg.frames;
        end
        else if (state_reg.daddr == qdac_pkg::OFS_ABORTS)
        begin
          state_next.rdata[qdac_pkg::EVT_W-1:0] = state_reg.aborts;
        end
        else if (state_reg.daddr == qdac_pkg::OFS_SHUTDOWN)
        begin
          state_next.rdata[qdac_pkg::SHUTDOWN_FLAGS_POS +: qdac_pkg::CH_N] = state_reg.shutdown;
          state_next.rdata[qdac_pkg::SHUTDOWN_TERM_POS +: 2*qdac_pkg::CH_N] = state_reg.term;
        end
        else if (state_reg.daddr >= qdac_pkg::OFS_INPUT_BASE &&
                 state_reg.daddr <= qdac_pkg::OFS_LAST)
        begin
          state_next.rdata[qdac_pkg::DATA_W-1:0] = bank_rdata;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= '0;
      state_reg.st <= qdac_pkg::st_idle;
      state_reg.en <= qdac_pkg::CTRL_EN_RESET;
      state_reg.ready <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata = state_reg.rdata;
  assign hreadyout = state_reg.ready;
  assign hresp = qdac_pkg::HRESP_OKAY;
  assign conv_out.code = conv_code;
  assign conv_out.output_shutdown = state_reg.shutdown;
  assign conv_out.term = state_reg.term;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_last_edge;
    state_reg.st == qdac_pkg::st_shift && strobe_low && sclk_fall &&
    state_reg.bit_cnt == qdac_pkg::LAST_BIT_IDX;
  endsequence

  sequence s_commit_then_hold;
    state_reg.commit && state_reg.st == qdac_pkg::st_hold;
  endsequence

  sequence s_early_release;
    state_reg.st == qdac_pkg::st_shift && !strobe_low;
  endsequence

  a_count_clear_high: assert property (
    !strobe_low |=> state_reg.bit_cnt == '0)
    else $error("bit counter not cleared while strobe high");

  a_level_starts_frame: assert property (
    (state_reg.st == qdac_pkg::st_idle && strobe_low) |=> state_reg.st == qdac_pkg::st_shift)
    else $error("low strobe did not open a frame");

  a_idle_no_shift: assert property (
    (state_reg.st == qdac_pkg::st_idle) |=> $stable(state_reg.shreg))
    else $error("shift register moved outside a frame");

  a_msb_first_shift: assert property (
    (state_reg.st == qdac_pkg::st_shift && strobe_low && sclk_fall) |=>
    (state_reg.shreg[0] == $past(pins_s.sdin)) &&
    (state_reg.shreg[15:1] == $past(state_reg.shreg[14:0])))
    else $error("serial bit not shifted in at the bottom");

  a_commit_on_sixteen: assert property (
    s_last_edge |=> s_commit_then_hold ##1 !state_reg.commit)
    else $error("sixteenth edge did not commit exactly once");

  a_hold_ignores_edges: assert property (
    (state_reg.st == qdac_pkg::st_hold && sclk_fall) |=> $stable(state_reg.shreg))
    else $error("edge after sixteenth was taken");

  a_hold_until_release: assert property (
    (state_reg.st == qdac_pkg::st_hold && strobe_low) |=> state_reg.st == qdac_pkg::st_hold)
    else $error("new frame began without strobe release");

  a_abort_no_commit: assert property (
    s_early_release |=> !state_reg.commit && state_reg.st == qdac_pkg::st_idle &&
    state_reg.aborts == $past(state_reg.aborts) + 16'h0001 ##1 bank_wr.in_we == '0)
    else $error("aborted frame reached the registers");

  a_select_target: assert property (
    (state_reg.commit && !pd_cmd && load_act[0]) |->
    bank_wr.in_we == qdac_pkg::chan_onehot(state_reg.frame[13:12]))
    else $error("wrong channel input register written");

  a_all_conv_update: assert property (
    (state_reg.commit && !pd_cmd && load_act[1] && load_code == 2'h3) |->
    bank_wr.cv_we == 4'hf ##2 conv_out.code[3] == u_bank.state_reg.in_regs[3])
    else $error("both-ones code did not update every converter");

  a_shutdown_sets: assert property (
    (state_reg.commit && pd_cmd) |=> (state_reg.shutdown & $past(pd_mask)) == $past(pd_mask))
    else $error("power-down frame did not shut the channels");

  a_bus_one_wait: assert property (
    addr_take |=> !hreadyout ##1 hreadyout)
    else $error("bus transfer not answered after one wait state");
endmodule

//--- hdl/qdac_pkg.sv
/*
  Shared constants, types and helpers for the quad converter serial load block.
  Assumes a single 25 MHz system clock and word-wide AHB-Lite register access.
*/
package qdac_pkg;
  localparam int CH_N = 4;
  localparam int DATA_W = 12;
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int EVT_W = 16;
  localparam logic [4:0] LAST_BIT_IDX = 5'h0f;
  // Idle levels of the link pins {sync_n, sclk, sdin}
  localparam logic [2:0] PINS_IDLE = 3'h6;
  // Frame field positions
  localparam int LOAD_CTL_HI_POS = 15;
  localparam int LOAD_CTL_LO_POS = 14;
  localparam int CHAN_PICK_HI_POS = 13;
  localparam int CHAN_PICK_LO_POS = 12;
  localparam int ALL_CHANNEL_FLAG_POS = 11;
  localparam int PD_CHAN_HI_POS = 10;
  localparam int PD_CHAN_LO_POS = 9;
  localparam int PD_TERM_HI_POS = 8;
  localparam int PD_TERM_LO_POS = 7;
  localparam logic [3:0] PD_PREFIX = 4'hf;
  localparam logic [1:0] LOAD_ALL_UPDATE = 2'h3;
  // Per load code: bit 0 writes input register, bit 1 updates converter register
  localparam logic [7:0] LOAD_DECODE_DEFAULT = 8'hdd;
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FRAMES = 8'h04;
  localparam logic [7:0] OFS_ABORTS = 8'h08;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h0c;
  localparam logic [7:0] OFS_INPUT_BASE = 8'h10;
  localparam logic [7:0] OFS_CONV_BASE = 8'h20;
  localparam logic [7:0] OFS_LAST = 8'h2c;
  localparam int CTRL_EN_POS = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int SHUTDOWN_FLAGS_POS = 0;
  localparam int SHUTDOWN_TERM_POS = 4;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_shift = 3'b010,
    st_hold = 3'b100
  } link_state_e;

  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic sdin;
  } serial_pins_s;

  typedef struct packed {
    logic [CH_N-1:0][DATA_W-1:0] code;
    logic [CH_N-1:0] output_shutdown;
    logic [CH_N-1:0][1:0] term;
  } conv_out_s;

  typedef struct packed {
    logic [CH_N-1:0] in_we;
    logic [CH_N-1:0] cv_we;
    logic [CH_N-1:0] cv_from_shift;
    logic [DATA_W-1:0] wdata;
  } bank_wr_s;

  function automatic logic [CH_N-1:0] chan_onehot(input logic [1:0] sel);
    chan_onehot = 4'h1 << sel;
  endfunction
endpackage

//--- hdl/pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to clk; only the second stage is read outside.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_state_s;

  sync_state_s state_reg;
  sync_state_s state_next;

  always_comb
  begin
    state_next.meta = d;
    state_next.q = state_reg.meta;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Both stages start at the pins' idle levels, so no false edge follows reset
      state_reg <= {RST_VAL, RST_VAL};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.q;
endmodule

//--- hdl/chan_reg_bank.sv
/*
  Per-channel input and converter registers with a registered read port.
  Assumes write requests arrive from logic on clk; reads index 0..3 input, 4..7 converter.
*/
`timescale 1ns/1ps
module chan_reg_bank (
  input wire logic clk,
  input wire logic srst,
  input wire qdac_pkg::bank_wr_s wr,
  input wire logic [2:0] raddr,
  output logic [qdac_pkg::DATA_W-1:0] rdata,
  output logic [qdac_pkg::CH_N-1:0][qdac_pkg::DATA_W-1:0] conv_code
);
  typedef struct packed {
    logic [qdac_pkg::CH_N-1:0][qdac_pkg::DATA_W-1:0] in_regs;
    logic [qdac_pkg::CH_N-1:0][qdac_pkg::DATA_W-1:0] cv_regs;
    logic [qdac_pkg::DATA_W-1:0] rdata;
  } bank_state_s;

  bank_state_s state_reg;
  bank_state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < qdac_pkg::CH_N; i++)
    begin
      // Straight binary: the code is stored untouched
      if (wr.in_we[i])
      begin
        state_next.in_regs[i] = wr.wdata;
      end
      if (wr.cv_we[i])
      begin
        state_next.cv_regs[i] = wr.cv_from_shift[i] ? wr.wdata : state_reg.in_regs[i];
      end
    end
    state_next.rdata = raddr[2] ? state_reg.cv_regs[raddr[1:0]] : state_reg.in_regs[raddr[1:0]];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign conv_code = state_reg.cv_regs;

  a_reset_zero_scale: assert property (
    @(posedge clk) srst |=> (state_reg.cv_regs == '0) && (state_reg.in_regs == '0))
    else $error("converter registers not cleared by reset");

  a_code_passes_plain: assert property (
    @(posedge clk) disable iff (srst)
    (wr.cv_we[0] && wr.cv_from_shift[0]) |=> (state_reg.cv_regs[0] == $past(wr.wdata)))
    else $error("converter code altered on its way to the register");
endmodule

//--- tb/serial_host_model.sv
/*
  Host side model of the serial port: drives strobe, serial clock and data.
  Assumes clk is the 25 MHz system clock; one link half period is four clk cycles.
*/
`timescale 1ns/1ps
module serial_host_model (
  input wire logic clk,
  output qdac_pkg::serial_pins_s pins
);
  initial
  begin
    pins = '{sync_n: 1'b1, sclk: 1'b1, sdin: 1'b0};
  end

  task automatic half_period();
    repeat (4) @(posedge clk);
  endtask

  // Fewer than 16 bits aborts; more than 16 adds edges the device must ignore
  task automatic send_frame(input logic [15:0] w, input int nbits);
    logic [31:0] s;
    s = {w, 16'h5a3c};
    @(posedge clk);
    pins.sync_n <= 1'b0;
    half_period();
    for (int i = 0; i < nbits; i++)
    begin
      pins.sdin <= s[31-i];
      half_period();
      pins.sclk <= 1'b0;
      half_period();
      pins.sclk <= 1'b1;
    end
    half_period();
    pins.sync_n <= 1'b1;
    // Released data line shows the inverse of its last level
    pins.sdin <= ~pins.sdin;
    repeat (3) half_period();
  endtask
endmodule

//--- tb/quad_dac_serial_load_tb_top.sv
/*
  Self-checking bench for the quad converter serial load block.
  Assumes the host model drives the link pins and the bench is the only bus master.
*/
`timescale 1ns/1ps
module quad_dac_serial_load_tb_top;
  logic clk;
  logic srst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  qdac_pkg::serial_pins_s link_pins;
  qdac_pkg::conv_out_s conv_out;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [11:0] in_e [4];
  logic [11:0] cv_e [4];
  logic [3:0] sd_e = 4'h0;
  logic [7:0] term_e = 8'h00;
  logic [15:0] fr_e = 16'h0000;
  logic [15:0] ab_e = 16'h0000;

  assign hready = hreadyout;

  quad_dac_serial_load uut (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .link_pins(link_pins), .conv_out(conv_out)
  );

  serial_host_model host (
    .clk(clk),
    .pins(link_pins)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits as long as the slave needs; only the cycle ceiling ends a hang
  task automatic wait_ready();
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      @(posedge clk);
    end
  endtask

  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(1'b0, a, 32'h0, d);
    check(d, exp);
  endtask

  task automatic check_all();
    for (int i = 0; i < 4; i++)
    begin
      read_check(qdac_pkg::OFS_INPUT_BASE + {i[5:0], 2'b00}, {20'h0, in_e[i]});
      read_check(qdac_pkg::OFS_CONV_BASE + {i[5:0], 2'b00}, {20'h0, cv_e[i]});
      check({20'h0, conv_out.code[i]}, {20'h0, cv_e[i]});
    end
    read_check(qdac_pkg::OFS_SHUTDOWN, {20'h0, term_e, sd_e});
    check({24'h0, conv_out.term}, {24'h0, term_e});
    check({28'h0, conv_out.output_shutdown}, {28'h0, sd_e});
    read_check(qdac_pkg::OFS_FRAMES, {16'h0, fr_e});
    read_check(qdac_pkg::OFS_ABORTS, {16'h0, ab_e});
  endtask

  task automatic expect_frame(input logic [15:0] w);
    logic [1:0] ch;
    logic [1:0] dec;
    ch = w[13:12];
    dec = qdac_pkg::LOAD_DECODE_DEFAULT[{w[15:14], 1'b0} +: 2];
    fr_e = fr_e + 16'h0001;
    for (int i = 0; i < 4; i++)
    begin
      if (w[15:12] == qdac_pkg::PD_PREFIX && (w[11] || w[10:9] == i[1:0]))
      begin
        sd_e[i] = 1'b1;
        term_e[2*i +: 2] = w[8:7];
      end
      else if (w[15:12] != qdac_pkg::PD_PREFIX && i[1:0] == ch)
      begin
        if (dec[0])
          in_e[i] = w[11:0];
        if (dec[1])
        begin
          cv_e[i] = w[11:0];
          sd_e[i] = 1'b0;
        end
      end
      else if (w[15:12] != qdac_pkg::PD_PREFIX && w[15:14] == 2'h3)
      begin
        cv_e[i] = in_e[i];
        sd_e[i] = 1'b0;
      end
    end
  endtask

  // Sends a frame, predicts its effect, then compares every register except the control register
  task automatic run(input logic [15:0] w, input int nbits, input logic en);
    host.send_frame(w, nbits);
    if (en && nbits >= 16)
      expect_frame(w);
    else if (en)
      ab_e = ab_e + 16'h0001;
    check_all();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    read_check(qdac_pkg::OFS_CTRL, 32'h1);
    read_check(8'h40, 32'h0);
    ahb_xfer(1'b1, qdac_pkg::OFS_FRAMES, 32'hffff, d);
    check({31'h0, hresp}, 32'h0);
    check_all();
    $display("test reset done");
  endtask

  task automatic t_load();
    for (int ld = 0; ld < 4; ld++)
      for (int ch = 0; ch < 4; ch++)
        run({ld[1:0], ch[1:0], ld[1:0], ch[1:0], 8'h5a} ^ {4'h0, {12{ch[0]}}}, 16, 1'b1);
    run(16'h3000, 16, 1'b1);
    $display("test load codes done");
  endtask

  task automatic t_abort();
    run(16'h1abc, 10, 1'b1);
    run(16'h1abc, 0, 1'b1);
    run(16'h2123, 18, 1'b1);
    run(16'h1321, 16, 1'b1);
    $display("test abort done");
  endtask

  task automatic t_powerdown();
    for (int t = 0; t < 4; t++)
      run({5'h1e, t[1:0], t[1:0], 7'h00}, 16, 1'b1);
    run(16'hf900, 16, 1'b1);
    run(16'h1a55, 16, 1'b1);
    run(16'hfa80, 16, 1'b1);
    run(16'hc777, 16, 1'b1);
    $display("test power down done");
  endtask

  task automatic t_disable();
    logic [31:0] d;
    ahb_xfer(1'b1, qdac_pkg::OFS_CTRL, 32'h0, d);
    read_check(qdac_pkg::OFS_CTRL, 32'h0);
    run(16'h1555, 16, 1'b0);
    ahb_xfer(1'b1, qdac_pkg::OFS_CTRL, 32'h1, d);
    run(16'h0444, 16, 1'b1);
    $display("test disable done");
  endtask

  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      in_e[i] = 12'h000;
      cv_e[i] = 12'h000;
    end
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_load();
    t_abort();
    t_powerdown();
    t_disable();
    conclude();
  end
endmodule
